// File: design/ssp_device.sv
// Purpose : Sensor end of the serial register-access port
// Assumes : Serial clock, select and data are sampled by the block clock
// Notes   : Serial clock half period must exceed four block clocks
//
// Behaviour
// - Device is secondary only, never starts transfers
// - Mode 0 only, clock idles low
// - Sample on rising edge, change on falling
// - Host holds select low for whole transfer
// - Single byte 24 clocks, plus 8 each
// - First bit is direction, 1 read
// - Next seven bits are address, MSB first
// - Second byte is ignored
// - Write data on pulses 17 to 24
// - 4-wire read shifts out on output line
// - Multi-byte read increments address per byte
// - Select rising edge ends the transaction
// - 4-wire after reset, setup bit selects 3-wire
// - 3-wire uses data pin both ways
// - 3-wire read drives D7 at fall 16
// - Output pin disabled in 3-wire mode
`default_nettype none
module ssp_device
    import ssp_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // Serial link
    ssp_if.device                  link,
    // Setup bit from sensor_setup_one, reset value zero
    input  wire logic              three_wire,
    // Register read port
    output logic      [ADDR_W-1:0] rd_addr,
    input  wire logic [BYTE_W-1:0] rd_data,
    // Register write stream
    output logic                   wr_valid,
    input  wire logic              wr_ready,
    output logic      [ADDR_W-1:0] wr_addr,
    output logic      [BYTE_W-1:0] wr_data,
    output logic                   wr_drop
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CMD   = 4'b0010,
        ST_DUMMY = 4'b0100,
        ST_DATA  = 4'b1000
    } ssp_dev_state_t;

    // =====================================================================
    // Link input synchronisers
    // =====================================================================
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic dq_s1;
    logic dq_s2;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d  <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            dq_s1   <= 1'b1;
            dq_s2   <= 1'b1;
        end else begin
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
            cs_s1   <= link.cs_n;
            cs_s2   <= cs_s1;
            dq_s1   <= link.dq_line;
            dq_s2   <= dq_s1;
        end
    end

    // =====================================================================
    // Edge and phase decode
    // =====================================================================
    ssp_dev_state_t    state;
    ssp_dev_state_t    next_state;
    logic [2:0]        bitn;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] tx_sh;
    logic              rnw;
    logic [ADDR_W-1:0] addr;
    logic              fifo_ready;

    wire               selected  = !cs_s2;
    wire               sclk_rise = sclk_s2 && !sclk_d;
    wire               sclk_fall = !sclk_s2 && sclk_d;
    wire               byte_end  = sclk_rise && (bitn == LAST_BIT);
    wire [BYTE_W-1:0]  rx_byte   = {rx_sh[BYTE_W-2:0], dq_s2};
    wire               in_data   = (state == ST_DATA);
    wire               rd_fall   = in_data && rnw && sclk_fall;
    wire               rd_load   = rd_fall && (bitn == 3'h0);
    wire               wr_push   = in_data && !rnw && byte_end;
    wire [FIFO_W-1:0]  push_word = {addr, rx_byte};

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (selected) next_state = ST_CMD;
            ST_CMD:   if (byte_end) next_state = ST_DUMMY;
            ST_DUMMY: if (byte_end) next_state = ST_DATA;
            ST_DATA:  next_state = ST_DATA;
            default:  next_state = ST_IDLE;
        endcase
        if (!selected) begin
            next_state = ST_IDLE;
        end
    end

    // =====================================================================
    // Frame state, shift-in and address
    // =====================================================================
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            bitn  <= 3'h0;
            rx_sh <= '0;
            rnw   <= DIR_WRITE;
            addr  <= '0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) begin
                bitn <= 3'h0;
            end else if (sclk_rise) begin
                bitn  <= bitn + 3'h1;
                rx_sh <= rx_byte;
            end
            if (state == ST_CMD && sclk_rise && bitn == 3'h0) begin
                rnw <= dq_s2;
            end
            if (state == ST_CMD && byte_end) begin
                addr <= rx_byte[ADDR_W-1:0];
            end else if (in_data && byte_end) begin
                addr <= addr + ADDR_ONE;
            end
        end
    end

    // =====================================================================
    // Read data shift-out and pin drivers
    // =====================================================================
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_sh             <= '0;
            link.dev_dq_out   <= 1'b1;
            link.dev_dq_oe    <= 1'b0;
            link.dev_miso_out <= 1'b1;
            link.dev_miso_oe  <= 1'b0;
        end else begin
            if (!selected || !in_data || !rnw) begin
                link.dev_dq_oe   <= 1'b0;
                link.dev_miso_oe <= 1'b0;
            end else if (rd_fall) begin
                link.dev_dq_oe   <= three_wire;
                link.dev_miso_oe <= !three_wire;
            end
            if (rd_load) begin
                link.dev_dq_out   <= rd_data[BYTE_W-1];
                link.dev_miso_out <= rd_data[BYTE_W-1];
                tx_sh             <= {rd_data[BYTE_W-2:0], 1'b0};
            end else if (rd_fall) begin
                link.dev_dq_out   <= tx_sh[BYTE_W-1];
                link.dev_miso_out <= tx_sh[BYTE_W-1];
                tx_sh             <= {tx_sh[BYTE_W-2:0], 1'b0};
            end
        end
    end

    // =====================================================================
    // Register side
    // =====================================================================
    // Read address follows the frame address; data must settle before next fall
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_addr <= '0;
            wr_drop <= 1'b0;
        end else begin
            rd_addr <= addr;
            // Serial link cannot stall, so a byte met by a full FIFO is lost
            wr_drop <= wr_push && !fifo_ready;
        end
    end

    ssp_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clock     (clock),
        .resetn    (resetn),
        .in_valid  (wr_push),
        .in_ready  (fifo_ready),
        .in_data   (push_word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_addr, wr_data})
    );
endmodule
`default_nettype wire

// File: design/ssp_fifo.sv
// Purpose : Write-byte FIFO between serial port and register file
// Assumes : DEPTH is a power of two
// Notes   : Output stage is registered, so capacity is DEPTH plus one
`default_nettype none
module ssp_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    rptr;
    logic [PW:0]      count;
    wire              push;
    wire              take;
    wire  [PW:0]      next_count;

    assign in_ready   = count != (PW+1)'(DEPTH);
    assign push       = in_valid && in_ready;
    assign take       = (count != '0) && (!out_valid || out_ready);
    assign next_count = count + (PW+1)'(push) - (PW+1)'(take);

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wptr      <= '0;
            rptr      <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            count <= next_count;
            if (push) begin
                wptr <= wptr + PW'(1);
            end
            if (take) begin
                out_data  <= mem[rptr];
                rptr      <= rptr + PW'(1);
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: design/ssp_host.sv
// Purpose : Host end of the serial register-access port
// Assumes : Device samples the link with at least two flops
// Notes   : Serial clock is divided from the block clock
`default_nettype none
module ssp_host
    import ssp_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              resetn,
    // Serial link
    ssp_if.host                    link,
    // Command
    input  wire logic              start,
    input  wire logic              read_not_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [LEN_W-1:0]  byte_count,
    input  wire logic              three_wire,
    // Data
    input  wire logic [BYTE_W-1:0] tx_data,
    output logic                   tx_take,
    output logic                   rx_valid,
    output logic      [BYTE_W-1:0] rx_data,
    output logic                   busy
);
    typedef enum logic [4:0] {
        HS_IDLE  = 5'b00001,
        HS_LEAD  = 5'b00010,
        HS_SHIFT = 5'b00100,
        HS_TAIL  = 5'b01000,
        HS_GAP   = 5'b10000
    } ssp_host_state_t;

    ssp_host_state_t   state;
    logic [7:0]        div;
    logic [2:0]        bitn;
    // One bit wider than byte_count: 31 data bytes plus command and dummy make 33
    logic [LEN_W:0]    byten;
    logic [LEN_W:0]    last_byte;
    logic              rnw;
    logic              mode3;
    logic              last_done;
    logic [BYTE_W-1:0] tx_sh;
    logic [BYTE_W-1:0] rx_sh;
    logic              in_s1;
    logic              in_s2;

    wire               tick     = div == 8'(HALF_CYC - 1);
    wire               rise     = (state == HS_SHIFT) && tick && !link.sclk;
    wire               fall     = (state == HS_SHIFT) && tick && link.sclk;
    wire               new_byte = fall && bitn == 3'h0;
    wire [LEN_W:0]     data_first = {1'b0, DATA_BYTE0};
    wire [BYTE_W-1:0]  next_tx  = (byten == (LEN_W+1)'(1)) ? DUMMY_BYTE : tx_data;
    wire               in_pin   = mode3 ? link.dq_line : link.miso_line;

    // Return line passes two flops before use
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_s1 <= 1'b1;
            in_s2 <= 1'b1;
        end else begin
            in_s1 <= in_pin;
            in_s2 <= in_s1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= HS_IDLE;
            div   <= 8'h00;
        end else begin
            div <= (state == HS_IDLE || tick) ? 8'h00 : div + 8'h01;
            unique case (state)
                HS_IDLE:  if (start) state <= HS_LEAD;
                HS_LEAD:  if (tick) state <= HS_SHIFT;
                HS_SHIFT: if (fall && last_done) state <= HS_TAIL;
                HS_TAIL:  if (tick) state <= HS_GAP;
                HS_GAP:   if (tick) state <= HS_IDLE;
                default:  state <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.sclk        <= 1'b0;
            link.cs_n        <= 1'b1;
            link.host_dq_out <= 1'b1;
            link.host_dq_oe  <= 1'b0;
            bitn      <= 3'h0;
            byten     <= '0;
            last_byte <= '0;
            rnw       <= DIR_WRITE;
            mode3     <= 1'b0;
            last_done <= 1'b0;
            tx_sh     <= '0;
            rx_sh     <= '0;
            rx_data   <= '0;
            rx_valid  <= 1'b0;
            tx_take   <= 1'b0;
            busy      <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            tx_take  <= 1'b0;
            if (state == HS_IDLE && start) begin
                link.cs_n        <= 1'b0;
                link.host_dq_oe  <= 1'b1;
                link.host_dq_out <= read_not_write;
                tx_sh     <= {addr, 1'b0};
                rnw       <= read_not_write;
                mode3     <= three_wire;
                last_byte <= {1'b0, byte_count} + (LEN_W+1)'(1);
                bitn      <= 3'h0;
                byten     <= '0;
                last_done <= 1'b0;
                busy      <= 1'b1;
            end
            if (rise) begin
                link.sclk <= 1'b1;
                bitn      <= bitn + 3'h1;
                rx_sh     <= {rx_sh[BYTE_W-2:0], in_s2};
                if (bitn == LAST_BIT) begin
                    byten     <= byten + (LEN_W+1)'(1);
                    last_done <= byten == last_byte;
                    if (rnw && byten >= data_first) begin
                        rx_data  <= {rx_sh[BYTE_W-2:0], in_s2};
                        rx_valid <= 1'b1;
                    end
                end
            end
            if (fall) begin
                link.sclk <= 1'b0;
                if (new_byte) begin
                    link.host_dq_out <= next_tx[BYTE_W-1];
                    tx_sh            <= {next_tx[BYTE_W-2:0], 1'b0};
                    tx_take          <= !rnw && byten >= data_first;
                    if (rnw && mode3 && byten == data_first) begin
                        link.host_dq_oe <= 1'b0;
                    end
                end else begin
                    link.host_dq_out <= tx_sh[BYTE_W-1];
                    tx_sh            <= {tx_sh[BYTE_W-2:0], 1'b0};
                end
            end
            if (state == HS_TAIL && tick) begin
                link.cs_n       <= 1'b1;
                link.host_dq_oe <= 1'b0;
            end
            if (state == HS_GAP && tick) begin
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: inc/ssp_if.sv
// Purpose : Serial link between host and sensor port
// Assumes : Open-drain style pull-up on idle data lines
// Notes   : Wire levels are resolved here from the enables
`default_nettype none
interface ssp_if;
    logic sclk;
    logic cs_n;
    logic host_dq_out;
    logic host_dq_oe;
    logic dev_dq_out;
    logic dev_dq_oe;
    logic dev_miso_out;
    logic dev_miso_oe;
    wire  dq_line;
    wire  miso_line;

    // Undriven lines float high through the pull-up
    assign dq_line   = host_dq_oe ? host_dq_out : (dev_dq_oe ? dev_dq_out : 1'b1);
    assign miso_line = dev_miso_oe ? dev_miso_out : 1'b1;

    modport host (output sclk, output cs_n, output host_dq_out, output host_dq_oe,
                  input dq_line, input miso_line);
    modport device (input sclk, input cs_n, input dq_line,
                    output dev_dq_out, output dev_dq_oe, output dev_miso_out, output dev_miso_oe);
endinterface
`default_nettype wire

// File: inc/ssp_pkg.sv
// Purpose : Shared constants for the sensor serial secondary port
// Assumes : Block clock of 20 MHz on both ends
// Notes   : Host divides its own clock to make the serial clock
`default_nettype none
package ssp_pkg;
    localparam int          CLK_PERIOD_NS = 50;
    // Host serial clock half period; slow enough for two-flop sampling both ways
    localparam int          SCLK_HALF_NS  = 400;
    localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ADDR_W        = 7;
    localparam int          BYTE_W        = 8;
    localparam int          LEN_W         = 5;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          FIFO_W        = ADDR_W + BYTE_W;
    localparam logic        DIR_READ      = 1'b1;
    localparam logic        DIR_WRITE     = 1'b0;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [LEN_W-1:0] DATA_BYTE0 = 5'h02;
    localparam logic [BYTE_W-1:0] DUMMY_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ONE  = 7'h01;
endpackage
`default_nettype wire

// File: verif/sensor_spi_secondary_port_tb.sv
// Purpose : Self-checking bench for both ends of the serial port
// Assumes : Register file modelled by a bench memory
// Notes   : Write stream stalls at random to exercise the FIFO
`default_nettype none
module sensor_spi_secondary_port_tb;
    import ssp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clock      = 1'b0;
    logic              resetn     = 1'b0;
    logic              start      = 1'b0;
    logic              rnw        = 1'b0;
    logic [ADDR_W-1:0] addr       = 7'h00;
    logic [LEN_W-1:0]  byte_count = 5'h01;
    logic              tw         = 1'b0;
    logic [BYTE_W-1:0] tx_data    = 8'h00;
    logic              wr_ready   = 1'b0;
    logic              hold       = 1'b0;
    logic              tx_take, rx_valid, busy, wr_valid, wr_drop;
    logic [BYTE_W-1:0] rx_data, rd_data, wr_data;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [BYTE_W-1:0] mem [128];
    logic [BYTE_W-1:0] tx_buf [32];
    logic [14:0]       exp_wr [$];
    logic [7:0]        exp_rx [$];
    int                tx_idx, mismatches, comparisons, drops, t, n;
    logic [ADDR_W-1:0] a;

    ssp_if link_if ();
    ssp_host u_ssp_host (.clock(clock), .resetn(resetn), .link(link_if), .start(start), .read_not_write(rnw),
        .addr(addr), .byte_count(byte_count), .three_wire(tw), .tx_data(tx_data), .tx_take(tx_take),
        .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy));
    ssp_device #(.FIFO_DEPTH_P(FIFO_DEPTH)) u_ssp_device (.clock(clock), .resetn(resetn), .link(link_if),
        .three_wire(tw), .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_drop(wr_drop));
    ssp_properties u_ssp_properties (.clock(clock), .resetn(resetn), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
        .host_dq_out(link_if.host_dq_out), .host_dq_oe(link_if.host_dq_oe), .dev_dq_out(link_if.dev_dq_out),
        .dev_dq_oe(link_if.dev_dq_oe), .dev_miso_out(link_if.dev_miso_out), .dev_miso_oe(link_if.dev_miso_oe),
        .three_wire(tw));

    assign rd_data = mem[rd_addr];
    always #25 clock = ~clock;

    // ==========================================
    // Compare and verdict
    task automatic check_wr(input logic [14:0] exp, input logic [14:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value write word expected %h seen %h", exp, got);
        end
    endtask
    task automatic check_rx(input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value read byte expected %h seen %h", exp, got);
        end
    endtask
    task automatic check_cnt(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Register file side and host data feed
    always @(posedge clock) begin
        wr_ready <= !hold && ($urandom_range(3) != 0);
        if (wr_drop === 1'b1) drops++;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            mem[wr_addr] <= wr_data;
            check_wr(exp_wr.size() ? exp_wr.pop_front() : 15'hXXXX, {wr_addr, wr_data});
        end
        if (rx_valid === 1'b1) check_rx(exp_rx.size() ? exp_rx.pop_front() : 8'hXX, rx_data);
        if (tx_take === 1'b1) begin
            tx_idx  <= tx_idx + 1;
            tx_data <= tx_buf[(tx_idx + 1) % 32];
        end
    end

    // Waits until the write queue holds no more than left words
    task automatic drain(input int left);
        int k;
        for (k = 0; k < 400 && exp_wr.size() > left; k++) @(negedge clock);
        check_cnt("words pending", left, exp_wr.size());
        if (exp_wr.size() > left) begin
            print_verdict();
        end
    endtask

    task automatic xfer(input logic r, input logic [6:0] sa, input int cnt, input int keep);
        int k;
        for (k = 0; k < cnt; k++) begin
            tx_buf[k] = 8'($urandom);
            if (r) exp_rx.push_back(mem[7'(sa + k)]);
            else if (k < keep) exp_wr.push_back({7'(sa + k), tx_buf[k]});
        end
        @(posedge clock);
        rnw        <= r;
        addr       <= sa;
        byte_count <= 5'(cnt);
        tx_data    <= tx_buf[0];
        tx_idx     <= 0;
        start      <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        for (k = 0; k < 20000 && busy !== 1'b0; k++) @(negedge clock);
        if (k == 20000) begin
            mismatches++;
            print_verdict();
        end
        check_cnt("bytes pending", 0, exp_rx.size());
        drain(hold ? keep : 0);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(79));
        for (t = 0; t < 128; t++) mem[t] = 8'($urandom);
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        for (t = 0; t < 8; t++) begin
            @(posedge clock);
            tw <= t[2];
            repeat (4) @(posedge clock);
            a = (t[1:0] == 2'h1) ? 7'h7E : 7'($urandom);
            n = (t[1:0] == 2'h0) ? 1 : ((t[1:0] == 2'h3) ? 30 : 1 + $urandom_range(6));
            xfer(DIR_WRITE, a, n, n);
            xfer(DIR_READ, a, n + 1, 0);
            $display("test %0d done, three-wire %0d, %0d bytes", t, t[2], n);
        end
        check_cnt("dropped", 0, drops);
        @(posedge clock);
        hold <= 1'b1;
        drops = 0;
        xfer(DIR_WRITE, 7'h10, 12, FIFO_DEPTH + 1);
        check_cnt("dropped", 12 - FIFO_DEPTH - 1, drops);
        @(posedge clock);
        hold <= 1'b0;
        drain(0);
        xfer(DIR_READ, 7'h10, 9, 0);
        $display("test fifo overflow done");
        print_verdict();
    end
endmodule
`default_nettype wire

// File: verif/ssp_properties.sv
// Purpose : Link assertions for the sensor serial port
// Assumes : Both ends are design modules on one link
// Notes   : Serial pulses are counted with the block clock
`default_nettype none
module ssp_properties (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Link
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic host_dq_out,
    input  wire logic host_dq_oe,
    input  wire logic dev_dq_out,
    input  wire logic dev_dq_oe,
    input  wire logic dev_miso_out,
    input  wire logic dev_miso_oe,
    // Wire-count select
    input  wire logic three_wire
);
    logic       prev_sclk;
    logic [8:0] pulses;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // ==========================================
    // Rising serial pulses within a frame
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_sclk <= 1'b0;
            pulses    <= 9'h000;
        end else begin
            prev_sclk <= sclk;
            pulses    <= cs_n ? 9'h000 : pulses + {8'h00, sclk & ~prev_sclk};
        end
    end

    // ==========================================
    // Link properties
    clock_idle_a: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    frame_setup_a: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("serial clock moved too soon after select");
    frame_len_a: assert property ($rose(cs_n) |-> pulses >= 9'h018 && pulses[2:0] == 3'h0)
        else $error("frame not 24 plus a multiple of 8 pulses");
    host_change_a: assert property ($changed(host_dq_out) && host_dq_oe |-> !sclk)
        else $error("host data changed while clock high");
    dev_change_a: assert property ($changed(dev_miso_out) && dev_miso_oe && $past(dev_miso_oe) |-> !sclk)
        else $error("output pin changed while clock high");
    miso_start_a: assert property ($rose(dev_miso_oe) |-> pulses == 9'h010 && !sclk)
        else $error("output pin enabled outside pulse 16 fall");
    dq_turn_a: assert property ($rose(dev_dq_oe) |-> pulses == 9'h010 && !host_dq_oe)
        else $error("shared pin turned outside pulse 16 fall");
    miso_off_a: assert property (three_wire |-> !dev_miso_oe)
        else $error("output pin driven in three-wire mode");
    dq_four_a: assert property (!three_wire |-> !dev_dq_oe)
        else $error("shared pin driven by device in four-wire mode");
    release_a: assert property ($rose(cs_n) |-> ##[1:6] !dev_miso_oe && !dev_dq_oe)
        else $error("device still driving after select rose");
    idle_quiet_a: assert property (cs_n [*6] |-> !dev_miso_oe && !dev_dq_oe)
        else $error("device driving while not selected");
endmodule
`default_nettype wire
